// ---- jrm_tap_top.sv ----
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module jrm_tap_top
#(
    // Silicon revision nibble; value is arbitrary
    parameter logic [3:0] SILICON_REV = 4'h1,
    // Part code, bit 0 must be one; value is arbitrary
    parameter logic [27:0] PART_CODE = 28'h0123451
)
(
    // Clock and system reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Test port pins
    input wire jrm_pkg::jrm_jtag_in_s jtag_in,
    output logic tdo,
    output logic tdo_oe_n,
    // Debug mode pins and latched mode
    input wire logic [1:0] debug_mode_pins,
    output logic bscan_mode,
    output logic emul_mode
);
    import jrm_pkg::*;

    // Phase detection needs two samples per test clock phase
    if (TCK_PHASE_MIN_CYC < 2)
    begin : g_chk
        $error("Clock too slow to sample the test clock");
    end
    if (PART_CODE[0] != 1'b1)
    begin : g_chk_id
        $error("Identity word bit 0 must be one");
    end

    // Decode of register addresses, used by both bus channels
    function automatic logic addr_mapped(input logic [31:0] a);
        addr_mapped = (a == ADDR_ID) || (a == ADDR_STAT)
            || (a == ADDR_CTRL);
    endfunction

    // Synchroniser stages; no system reset so test logic runs on
    jrm_jtag_in_s sy1_reg;
    jrm_jtag_in_s sy2_reg;
    logic [1:0] msy1_reg;
    logic [1:0] msy2_reg;
    logic tck_d_reg;
    logic trst_d_reg;

    // Test access port state
    jrm_tap_e tap_reg;
    jrm_tap_e tap_next;
    logic [IR_LEN-1:0] ir_reg;
    logic [IR_LEN-1:0] ir_sh_reg;
    logic [31:0] dr_reg;
    logic tdo_reg;
    logic tdo_oe_n_reg;

    // Functional state under system reset
    logic [3:0] rev_reg;
    logic [1:0] mode_raw_reg;
    logic mode_valid_reg;
    logic bscan_reg;
    logic emul_reg;
    logic [31:0] ctrl_reg;

    // Bus state
    logic awready_reg;
    logic wready_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [31:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rd_addr_reg;

    // Derived strobes
    logic tck_rise;
    logic tck_fall;
    logic trst_asrt;
    logic trst_rise;
    logic [31:0] id_word;

    // Two flops on every pin before use
    always_ff @(posedge aclk)
    begin
        sy1_reg <= jtag_in;
        sy2_reg <= sy1_reg;
        msy1_reg <= debug_mode_pins;
        msy2_reg <= msy1_reg;
        tck_d_reg <= sy2_reg.tck;
        trst_d_reg <= trst_asrt;
    end

    // Undriven line counts as asserted, like a pulldown   [RULE_08]
    assign trst_asrt = !(sy2_reg.trst_n && sy2_reg.trst_drv);
    assign trst_rise = trst_d_reg && !trst_asrt;
    // Edges only from the second stage onward
    assign tck_rise = sy2_reg.tck && !tck_d_reg;
    assign tck_fall = !sy2_reg.tck && tck_d_reg;
    // Revision on top, part code below   [RULE_13]
    assign id_word = {rev_reg, PART_CODE};

    // Next state of the standard test port machine
    always_comb
    begin
        tap_next = tap_reg;
        unique case (tap_reg)
            TS_TLR: tap_next = sy2_reg.tms ? TS_TLR : TS_RTI;
            TS_RTI: tap_next = sy2_reg.tms ? TS_SELDR : TS_RTI;
            TS_SELDR: tap_next = sy2_reg.tms ? TS_SELIR : TS_CAPDR;
            TS_CAPDR: tap_next = sy2_reg.tms ? TS_EX1DR : TS_SHDR;
            TS_SHDR: tap_next = sy2_reg.tms ? TS_EX1DR : TS_SHDR;
            TS_EX1DR: tap_next = sy2_reg.tms ? TS_UPDR : TS_PADR;
            TS_PADR: tap_next = sy2_reg.tms ? TS_EX2DR : TS_PADR;
            TS_EX2DR: tap_next = sy2_reg.tms ? TS_UPDR : TS_SHDR;
            TS_UPDR: tap_next = sy2_reg.tms ? TS_SELDR : TS_RTI;
            TS_SELIR: tap_next = sy2_reg.tms ? TS_TLR : TS_CAPIR;
            TS_CAPIR: tap_next = sy2_reg.tms ? TS_EX1IR : TS_SHIR;
            TS_SHIR: tap_next = sy2_reg.tms ? TS_EX1IR : TS_SHIR;
            TS_EX1IR: tap_next = sy2_reg.tms ? TS_UPIR : TS_PAIR;
            TS_PAIR: tap_next = sy2_reg.tms ? TS_EX2IR : TS_PAIR;
            TS_EX2IR: tap_next = sy2_reg.tms ? TS_UPIR : TS_SHIR;
            TS_UPIR: tap_next = sy2_reg.tms ? TS_SELDR : TS_RTI;
            // Corrupt code recovers through reset state
            default: tap_next = TS_TLR;
        endcase
    end

    // State register; only the test reset clears it   [RULE_02]
    always_ff @(posedge aclk)
    begin
        if (trst_asrt)
            tap_reg <= TS_TLR;  // [RULE_14] [RULE_04]
        else if (tck_rise)
            tap_reg <= tap_next;
    end

    // Instruction path; unknown codes act as bypass   [RULE_07]
    always_ff @(posedge aclk)
    begin
        if (trst_asrt || (tck_rise && tap_reg == TS_TLR))
        begin
            ir_reg <= IR_IDCODE;  // [RULE_14]
            ir_sh_reg <= IR_CAPTURE;
        end
        else if (tck_rise)
        begin
            if (tap_reg == TS_CAPIR)
                ir_sh_reg <= IR_CAPTURE;
            else if (tap_reg == TS_SHIR)
                ir_sh_reg <= {sy2_reg.tdi, ir_sh_reg[IR_LEN-1:1]};
            else if (tap_reg == TS_UPIR)
                ir_reg <= ir_sh_reg;
        end
    end

    // Data path: identity or one-bit bypass, system reset ignored
    always_ff @(posedge aclk)
    begin
        if (trst_asrt)
            dr_reg <= 32'h00000000;
        else if (tck_rise && tap_reg == TS_CAPDR)
            // Variant reads zero while system reset is held  [RULE_06]
            dr_reg <= (ir_reg == IR_IDCODE) ? id_word : 32'h00000000;
        else if (tck_rise && tap_reg == TS_SHDR)
        begin
            if (ir_reg == IR_IDCODE)
                dr_reg <= {sy2_reg.tdi, dr_reg[31:1]};
            else
                dr_reg[0] <= sy2_reg.tdi;  // [RULE_07]
        end
    end

    // Output pin changes on the falling test clock edge
    always_ff @(posedge aclk)
    begin
        if (trst_asrt)
        begin
            tdo_reg <= 1'b1;
            tdo_oe_n_reg <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_reg <= (tap_reg == TS_SHIR) ? ir_sh_reg[0] : dr_reg[0];
            // Software can keep the pin released
            tdo_oe_n_reg <= !((tap_reg == TS_SHIR || tap_reg == TS_SHDR)
                && !ctrl_reg[CTRL_TDO_OFF_BIT]);
        end
    end

    // Revision nibble only settles after system reset   [RULE_06]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rev_reg <= 4'h0;
        else
            rev_reg <= SILICON_REV;
    end

    // Mode pins caught on test reset release after boot  [RULE_10]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_raw_reg <= DBG_MODE_BSCAN;
            mode_valid_reg <= 1'b0;
            bscan_reg <= 1'b0;
            emul_reg <= 1'b0;
        end
        else if (trst_rise)
        begin
            mode_raw_reg <= msy2_reg;
            mode_valid_reg <= 1'b1;
            // Boundary scan on one code, emulation otherwise  [RULE_11]
            bscan_reg <= (msy2_reg == DBG_MODE_BSCAN);
            emul_reg <= (msy2_reg != DBG_MODE_BSCAN);
        end
    end

    // Write address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 32'h00000000;
        end
        else if (s_axi_awvalid && awready_reg)
        begin
            awready_reg <= 1'b0;
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        else if (bvalid_reg && s_axi_bready)
            aw_full_reg <= 1'b0;
        else if (!aw_full_reg && !bvalid_reg)
            awready_reg <= 1'b1;
    end

    // Write data holding stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_reg <= 1'b0;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end
        else if (s_axi_wvalid && wready_reg)
        begin
            wready_reg <= 1'b0;
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        else if (bvalid_reg && s_axi_bready)
            w_full_reg <= 1'b0;
        else if (!w_full_reg && !bvalid_reg)
            wready_reg <= 1'b1;
    end

    // Response once both halves are in; unmapped gets an error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (aw_full_reg && w_full_reg && !bvalid_reg)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Control register; identity and status writes are dropped [RULE_12]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_reg <= CTRL_RESET;  // [RULE_02]
        else if (aw_full_reg && w_full_reg && !bvalid_reg
            && aw_addr_reg == ADDR_CTRL && w_strb_reg[0])
            ctrl_reg[CTRL_TDO_OFF_BIT] <= w_data_reg[CTRL_TDO_OFF_BIT];
    end

    // Read channel; served whatever the test reset does   [RULE_03]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
            rd_addr_reg <= 32'h00000000;
        end
        else if (s_axi_arvalid && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rd_addr_reg <= s_axi_araddr;
            rresp_reg <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= 32'h00000000;
            if (s_axi_araddr == ADDR_ID)
                rdata_reg <= id_word;  // [RULE_12]
            else if (s_axi_araddr == ADDR_STAT)
            begin
                rdata_reg[STAT_VALID_BIT] <= mode_valid_reg;
                rdata_reg[STAT_EMUL_BIT] <= emul_reg;
                rdata_reg[STAT_RAW_LSB +: 2] <= mode_raw_reg;
                rdata_reg[STAT_TRST_BIT] <= trst_asrt;
                rdata_reg[STAT_TLR_BIT] <= (tap_reg == TS_TLR);
            end
            else if (s_axi_araddr == ADDR_CTRL)
                rdata_reg <= ctrl_reg;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
        else if (!rvalid_reg)
            arready_reg <= 1'b1;
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign tdo = tdo_reg;
    assign tdo_oe_n = tdo_oe_n_reg;
    assign bscan_mode = bscan_reg;
    assign emul_mode = emul_reg;

    // Checks next to the logic they guard
    a_tap_reset_hold: assert property (  // [RULE_14]
        @(posedge aclk) trst_asrt [*2] |=> tap_reg == TS_TLR && tdo_oe_n)
        else $error("State machine left reset state under test reset");
    a_trst_default: assert property (  // [RULE_08]
        @(posedge aclk) !sy2_reg.trst_drv |=> trst_d_reg)
        else $error("Undriven test reset not seen as asserted");
    a_mode_capture: assert property (  // [RULE_10]
        @(posedge aclk) disable iff (!aresetn)
        trst_rise |=> mode_valid_reg && mode_raw_reg == $past(msy2_reg))
        else $error("Mode pins not captured on test reset release");
    a_mode_select: assert property (  // [RULE_11]
        @(posedge aclk) disable iff (!aresetn)
        mode_valid_reg |-> (bscan_mode != emul_mode)
        && (emul_mode == (mode_raw_reg != DBG_MODE_BSCAN)))
        else $error("Mode outputs disagree with captured value");
    a_id_value: assert property (  // [RULE_12] [RULE_13]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && arready_reg && s_axi_araddr == ADDR_ID
        |=> s_axi_rvalid && s_axi_rdata == {SILICON_REV, PART_CODE})
        else $error("Identity read returned a wrong word");
    a_variant_reset: assert property (  // [RULE_06]
        @(posedge aclk) !aresetn |=> rev_reg == 4'h0)
        else $error("Variant nibble not cleared by system reset");
    a_read_under_trst: assert property (  // [RULE_03] [RULE_04]
        @(posedge aclk) disable iff (!aresetn)
        trst_asrt && s_axi_arvalid && arready_reg |=> rvalid_reg)
        else $error("Bus read stalled while test reset held");
    a_sys_reset: assert property (  // [RULE_02]
        @(posedge aclk) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
        && ctrl_reg == CTRL_RESET)
        else $error("System reset left functional state");
    a_bypass_path: assert property (  // [RULE_07]
        @(posedge aclk) disable iff (trst_asrt)
        tck_rise && tap_reg == TS_SHDR && ir_reg != IR_IDCODE
        |=> dr_reg[0] == $past(sy2_reg.tdi))
        else $error("Bypass bit did not follow test data in");

    // Main scenarios
    c_emul_capture: cover property (
        @(posedge aclk) aresetn && trst_rise && msy2_reg != DBG_MODE_BSCAN);
    c_id_read: cover property (
        @(posedge aclk) rvalid_reg && s_axi_rready && rd_addr_reg == ADDR_ID);
    c_idcode_shift: cover property (
        @(posedge aclk) tap_reg == TS_SHDR && ir_reg == IR_IDCODE);
    c_ctrl_write: cover property (
        @(posedge aclk) bvalid_reg && aw_addr_reg == ADDR_CTRL);
endmodule
`default_nettype wire

// ---- jrm_pkg.sv ----
// Overview of operation
// [RULE_01] Environment asserts system reset and test reset
// [RULE_02] System reset clears functional logic, test reset test
// [RULE_03] Device runs after system reset despite test reset
// [RULE_04] Held test reset keeps port idle, function undisturbed
// [RULE_05] Controller keeps test clock running around test reset
// [RULE_06] Identity variant valid only with system reset released
// [RULE_07] Other instructions work under either system reset
// [RULE_08] Undriven test reset line reads as asserted
// [RULE_09] Passive controller pulses reset, then drives high
// [RULE_10] Mode pins captured on test reset release
// [RULE_11] Captured mode selects boundary scan or emulation
// [RULE_12] Read-only identity register, writes ignored
// [RULE_13] Top nibble revision, rest fixed part code
// [RULE_14] Test reset forces state machine to reset state
package jrm_pkg;
    // Register byte addresses on the AXI4-Lite bus
    localparam logic [31:0] ADDR_ID = 32'h01C40028;
    localparam logic [31:0] ADDR_STAT = 32'h01C4002C;
    localparam logic [31:0] ADDR_CTRL = 32'h01C40030;
    // Control register field and reset value
    localparam int CTRL_TDO_OFF_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    // Status register field positions
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_EMUL_BIT = 1;
    localparam int STAT_RAW_LSB = 2;
    localparam int STAT_TRST_BIT = 4;
    localparam int STAT_TLR_BIT = 5;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Mode pin value that selects boundary scan; others mean emulation
    localparam logic [1:0] DBG_MODE_BSCAN = 2'h0;
    // Instruction codes, capture pattern and width
    localparam int IR_LEN = 4;
    localparam logic [3:0] IR_IDCODE = 4'hE;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // Timing: shortest test clock phase against our clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCK_PHASE_MIN_NS = 20;
    localparam int TCK_PHASE_MIN_CYC =
        (TCK_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Test access port states, one-hot
    typedef enum logic [15:0] {
        TS_TLR = 16'h0001, TS_RTI = 16'h0002, TS_SELDR = 16'h0004,
        TS_CAPDR = 16'h0008, TS_SHDR = 16'h0010, TS_EX1DR = 16'h0020,
        TS_PADR = 16'h0040, TS_EX2DR = 16'h0080, TS_UPDR = 16'h0100,
        TS_SELIR = 16'h0200, TS_CAPIR = 16'h0400, TS_SHIR = 16'h0800,
        TS_EX1IR = 16'h1000, TS_PAIR = 16'h2000, TS_EX2IR = 16'h4000,
        TS_UPIR = 16'h8000
    } jrm_tap_e;
    // Test port pins as seen from outside the chip
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic trst_drv;
    } jrm_jtag_in_s;
endpackage

// ---- jrm_jtag_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module jrm_jtag_ctl
(
    // Clock that paces the test clock
    input wire logic aclk,
    // Pins toward the device
    output var jrm_pkg::jrm_jtag_in_s jtag_out,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    import jrm_pkg::*;
    // Set when the device drove tdo during the last scan
    logic saw_drive;
    // Last level read; a released line reads as its inverse
    logic last_tdo;
    // Test clock still, reset line undriven at power up
    initial
    begin
        jtag_out = '0;
        saw_drive = 1'b0;
        last_tdo = 1'b0;
    end
    // One test clock period, 40 ns low then 40 ns high
    task automatic clk(input logic tms, input logic tdi, output logic o);
        begin
            jtag_out.tms <= tms;
            jtag_out.tdi <= tdi;
            repeat (4) @(posedge aclk);
            // Read at the rise; tdo moved after the last fall
            if (tdo_oe_n === 1'b0)
            begin
                last_tdo = tdo;
                saw_drive = 1'b1;
            end
            else
            begin
                last_tdo = ~last_tdo;
            end
            o = last_tdo;
            jtag_out.tck <= 1'b1;
            repeat (4) @(posedge aclk);
            jtag_out.tck <= 1'b0;
        end
    endtask
    // Drive the reset line, low or high
    task automatic trst_set(input logic n);
        begin
            jtag_out.trst_drv <= 1'b1;
            jtag_out.trst_n <= n;
        end
    endtask
    // Pulse reset then drive high, clock kept running around it
    task automatic trst_pulse();
        logic o;
        begin
            trst_set(1'b0);
            repeat (2) clk(1'b1, 1'b0, o);
            trst_set(1'b1);
            repeat (2) clk(1'b1, 1'b0, o);
        end
    endtask
    // Five ones reach the reset state from anywhere, then idle
    task automatic tap_idle();
        logic o;
        begin
            repeat (5) clk(1'b1, 1'b0, o);
            clk(1'b0, 1'b0, o);
        end
    endtask
    // From idle through a scan of n bits, lsb first, back to idle
    task automatic shift(input logic ir, input int n,
        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        int i;
        begin
            dout = '0;
            saw_drive = 1'b0;
            clk(1'b1, 1'b0, o);
            if (ir)
                clk(1'b1, 1'b0, o);
            clk(1'b0, 1'b0, o);
            clk(1'b0, 1'b0, o);
            for (i = 0; i < n; i++)
            begin
                clk(i == n - 1, din[i], o);
                dout[i] = o;
            end
            clk(1'b1, 1'b0, o);
            // Data line keeps moving while nothing is scanned
            clk(1'b0, ~din[0], o);
        end
    endtask
endmodule
`default_nettype wire

// ---- jrm_tap_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module jrm_tap_top_tb_top;
    import jrm_pkg::*;
    // Revision and part code; values are arbitrary
    localparam logic [3:0] REV = 4'h5;
    localparam logic [27:0] PART = 28'h0ABCDE1;
    localparam logic [31:0] ID_WORD = {REV, PART};
    // An address that no register answers
    localparam logic [31:0] ADDR_BAD = 32'h01C40040;
    // Bus master side
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // Test port and mode pins
    jrm_jtag_in_s jtag;
    logic tdo, tdo_oe_n, bscan_mode, emul_mode;
    logic [1:0] debug_mode_pins = 2'h0;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] rnd = 32'h00011A13;
    always #5 aclk = ~aclk;
    jrm_tap_top #(.SILICON_REV(REV), .PART_CODE(PART)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .jtag_in(jtag), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .debug_mode_pins(debug_mode_pins),
        .bscan_mode(bscan_mode), .emul_mode(emul_mode));
    jrm_jtag_ctl ctl (.aclk(aclk), .jtag_out(jtag), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));
    // Shift register with taps 32, 22, 2, 1
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Eight-bit scan through the bypass stage, which captures 0
    function automatic logic [31:0] byp(input logic [31:0] x);
        return {24'h0, x[6:0], 1'b0};
    endfunction
    // Status after a capture with the port back in its reset state
    function automatic logic [31:0] stat_exp(input logic [1:0] c);
        return {26'h0, 1'b1, 1'b0, c, c != DBG_MODE_BSCAN, 1'b1};
    endfunction
    task automatic summarize();
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Compare and count
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
                n_errors++;
            end
        end
    endtask
    // One write; address and data offered together
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw, w;
        int i;
        begin
            aw = 1'b0;
            w = 1'b0;
            i = 0;
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(aw && w) && i < 50)
            begin
                @(posedge aclk);
                i++;
                aw = aw | (awready === 1'b1);
                w = w | (wready === 1'b1);
                if (aw)
                    awvalid <= 1'b0;
                if (w)
                    wvalid <= 1'b0;
            end
            do
            begin
                @(posedge aclk);
                i++;
            end
            while (bvalid !== 1'b1 && i < 100);
            r = bresp;
            bready <= 1'b0;
            @(posedge aclk);
            if (i >= 100)
            begin
                n_errors++;
                summarize();
            end
        end
    endtask
    // One read; the answer is taken at the edge where rvalid is high
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int i;
        begin
            i = 0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                i++;
            end
            while (arready !== 1'b1 && i < 50);
            arvalid <= 1'b0;
            do
            begin
                @(posedge aclk);
                i++;
            end
            while (rvalid !== 1'b1 && i < 100);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            @(posedge aclk);
            if (i >= 100)
            begin
                n_errors++;
                summarize();
            end
        end
    endtask
    // Main sequence; test reset is undriven from time zero
    initial
    begin
        logic [31:0] d, o;
        logic [1:0] r;
        logic b;
        int k;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        axi_rd(ADDR_STAT, d, r);
        check("stat_undriven", d & 32'h31, 32'h30);
        check("modes_idle", {bscan_mode, emul_mode}, 2'h0);
        axi_rd(ADDR_ID, d, r);
        check("id_word", d, ID_WORD);
        rnd = lfsr(rnd);
        axi_wr(ADDR_ID, rnd, r);
        check("id_wr_resp", {30'h0, r}, {30'h0, RESP_OKAY});
        axi_rd(ADDR_ID, d, r);
        check("id_kept", d, ID_WORD);
        axi_wr(ADDR_BAD, rnd, r);
        check("bad_wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        axi_rd(ADDR_BAD, d, r);
        check("bad_rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
        $display("test registers done");
        // Every mode code, latched on release and kept after
        for (k = 0; k < 4; k++)
        begin
            debug_mode_pins <= k[1:0];
            ctl.trst_pulse();
            repeat (6) @(posedge aclk);
            check("bscan", bscan_mode, k == 0);
            axi_rd(ADDR_STAT, d, r);
            check("stat_mode", d, stat_exp(k[1:0]));
            debug_mode_pins <= ~k[1:0];
            repeat (6) @(posedge aclk);
            check("emul_kept", emul_mode, k != 0);
        end
        $display("test modes done");
        ctl.tap_idle();
        ctl.shift(1'b1, 4, {28'h0, IR_IDCODE}, o);
        check("ir_capture", o, {28'h0, IR_CAPTURE});
        ctl.shift(1'b0, 32, rnd, o);
        check("idcode", o, ID_WORD);
        check("drive_seen", ctl.saw_drive, 1'b1);
        check("idle_release", tdo_oe_n, 1'b1);
        axi_wr(ADDR_CTRL, 32'h00000001, r);
        axi_rd(ADDR_CTRL, d, r);
        check("ctrl_set", d, 32'h00000001);
        ctl.shift(1'b0, 32, rnd, o);
        check("ctrl_quiet", ctl.saw_drive, 1'b0);
        ctl.shift(1'b1, 4, {28'h0, IR_BYPASS}, o);
        $display("test idcode done");
        // System reset clears function, leaves the test port alone
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(ADDR_CTRL, d, r);
        check("ctrl_reset", d, CTRL_RESET);
        check("modes_reset", {bscan_mode, emul_mode}, 2'h0);
        rnd = lfsr(rnd);
        ctl.shift(1'b0, 8, rnd, o);
        check("bypass_kept", o, byp(rnd));
        $display("test system reset done");
        // Other instructions under system reset
        aresetn <= 1'b0;
        for (k = 0; k < 3; k++)
        begin
            rnd = lfsr(rnd);
            d = (rnd[3:0] == IR_IDCODE) ? {28'h0, IR_BYPASS} : rnd & 32'hF;
            ctl.shift(1'b1, 4, d, o);
            ctl.shift(1'b0, 8, rnd >> 4, o);
            check("bypass_rst", o, byp(rnd >> 4));
        end
        debug_mode_pins <= 2'h3;
        ctl.trst_pulse();
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        check("no_capture", {bscan_mode, emul_mode}, 2'h0);
        $display("test under reset done");
        // Test reset in mid scan
        ctl.tap_idle();
        ctl.clk(1'b1, 1'b0, b);
        ctl.clk(1'b0, 1'b0, b);
        ctl.clk(1'b0, 1'b0, b);
        ctl.trst_set(1'b0);
        ctl.clk(1'b0, 1'b0, b);
        ctl.clk(1'b0, 1'b0, b);
        repeat (6) @(posedge aclk);
        check("trst_release", tdo_oe_n, 1'b1);
        axi_rd(ADDR_STAT, d, r);
        check("trst_tlr", d & 32'h30, 32'h30);
        ctl.trst_set(1'b1);
        ctl.tap_idle();
        $display("test mid scan reset done");
        summarize();
    end
endmodule
`default_nettype wire
